// ===== verilog/eipc_pkg.sv
// Overview of operation
// R1: Interrupt return clears level status, pops PC.
// R2: Subroutine return restores PC, keeps status.
// R3: Trigger type 0: low pin level requests.
// R4: Trigger type 1: high-then-low sample sets flag.
// R5: Source holds each level twelve oscillator periods.
// R6: Edge source: high one cycle, low one.
// R7: Edge flag cleared by hardware call.
// R8: Level source holds until call, releases before return.
// R9: Pins inverted, latched at state5_phase2, polled next.
// R10: Hardware call next, lasting two machine cycles.
// R11: Acknowledge waits for instruction final cycle.
// R12: Return or enable/priority access: wait one more.
// R13: Block while equal or higher level in progress.
// R14: Single source response between three and nine.
// R15: Level from high bit and low priority bit; source 6 has no bits, fixed at level 0.
// R16: Call pushes PC, no status word, loads vector.
// R17: Call clears external flag only in edge mode.
// R18: Equal levels resolved by fixed polling order.
package eipc_pkg;
    localparam int NUM_SRC = 7;
    localparam int OSC_PER_MCYCLE = 12;
    localparam int CLK_PER_OSC = 1;
    localparam int CALL_MCYCLES = 2;
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;
    localparam logic [3:0] PHASE_STATE5_PHASE2 = 4'h9;
    localparam logic [3:0] IP_RESET = 4'h0;
    typedef enum logic [1:0] {
        EIPC_IDLE = 2'b00,
        EIPC_CALL1 = 2'b01,
        EIPC_CALL2 = 2'b11
    } eipc_state_t;
endpackage

// ===== verilog/eipc_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface eipc_sync_if;
    logic [1:0] pin_n;
    logic [1:0] level_n;
    modport sync (input pin_n, output level_n);
    modport user (output pin_n, input level_n);
endinterface
`default_nettype wire

// ===== verilog/eipc_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module eipc_pin_sync (
    input wire logic clock_i,
    input wire logic rst_n_i,
    eipc_sync_if.sync port
);
    logic [1:0] s1_reg;
    logic [1:0] s2_reg;
    logic [1:0] s3_reg;
    logic [1:0] lvl_reg;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 2'h3;
            s2_reg <= 2'h3;
            s3_reg <= 2'h3;
        end else begin
            s1_reg <= port.pin_n;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // Change accepted once stages two and three agree
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_reg <= 2'h3;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (s2_reg[i] == s3_reg[i]) begin
                    lvl_reg[i] <= s3_reg[i];
                end
            end
        end
    end
    assign port.level_n = lvl_reg;
endmodule
`default_nettype wire

// ===== verilog/eipc_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module eipc_ctrl #(
    parameter int MCYCLE_CLKS = eipc_pkg::OSC_PER_MCYCLE * eipc_pkg::CLK_PER_OSC
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [1:0] ext_request_pin_n_i,
    input wire logic ext0_trigger_type_i,
    input wire logic ext1_trigger_type_i,
    input wire logic [6:0] interrupt_enable_bits_i,
    input wire logic [5:0] priority_low_bits_i,
    input wire logic [5:0] priority_high_bits_i,
    input wire logic [4:0] int_source_req_i,
    input wire logic instr_last_cycle_i,
    input wire logic instr_defer_next_i,
    input wire logic interrupt_return_instr_i,
    input wire logic subroutine_return_instr_i,
    input wire logic [15:0] pc_i,
    input wire logic [15:0] stack_pc_i,
    output logic mcycle_o,
    output logic ext0_request_flag_o,
    output logic ext1_request_flag_o,
    output logic [3:0] in_progress_o,
    output logic call_active_o,
    output logic push_o,
    output logic [15:0] push_data_o,
    output logic pop_o,
    output logic pc_load_o,
    output logic [15:0] pc_load_value_o,
    output logic [2:0] ack_source_o
);
    initial begin
        if (MCYCLE_CLKS < 10 || MCYCLE_CLKS > 16) begin
            $error("MCYCLE_CLKS must lie in 10..16");
        end
    end

    ////////////////////////////////////////////////////////////////
    // Machine cycle divider
    logic [3:0] phase_reg;
    logic state5_phase2;
    logic cyc_end;
    assign cyc_end = (phase_reg == 4'(MCYCLE_CLKS - 1));
    assign state5_phase2 = (phase_reg == eipc_pkg::PHASE_STATE5_PHASE2);
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= 4'h0;
        end else begin
            phase_reg <= cyc_end ? 4'h0 : phase_reg + 4'h1;
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mcycle_o <= 1'b0;
        end else begin
            mcycle_o <= cyc_end;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin sampling
    eipc_sync_if sif ();
    assign sif.pin_n = ext_request_pin_n_i;
    eipc_pin_sync u_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .port(sif.sync)
    );

    logic [1:0] trig;
    logic [1:0] prev_reg;
    logic [1:0] flag_reg;
    logic [1:0] ext_clr;
    assign trig = {ext1_trigger_type_i, ext0_trigger_type_i};
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg <= 2'h3;
        end else if (state5_phase2) begin
            prev_reg <= sif.level_n;
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (!trig[i]) begin
                    // Level mode mirrors inverted pin every sample
                    if (state5_phase2) flag_reg[i] <= ~sif.level_n[i]; // R3 R9
                end else if (state5_phase2 && prev_reg[i] && !sif.level_n[i]) begin
                    flag_reg[i] <= 1'b1; // R4 R9
                end else if (ext_clr[i]) begin
                    flag_reg[i] <= 1'b0; // R7 R17
                end
            end
        end
    end
    assign ext0_request_flag_o = flag_reg[0];
    assign ext1_request_flag_o = flag_reg[1];

    ////////////////////////////////////////////////////////////////
    // Priority resolution, polled in the cycle after latching
    logic [6:0] req;
    logic [1:0] lvl [7];
    logic [6:0] pend;
    logic found;
    logic [2:0] sel;
    logic [1:0] sel_lvl;
    logic [6:0] poll_reg;
    assign req = {int_source_req_i[4:1], flag_reg[1], int_source_req_i[0], flag_reg[0]};
    // Snapshot at cycle end, so a flag latched now is polled next cycle
    // Mask keeps a flag cleared by the call from being taken again
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            poll_reg <= 7'h00;
        end else if (cyc_end) begin
            poll_reg <= req & ~{4'h0, ext_clr[1], 1'b0, ext_clr[0]}; // R9
        end
    end
    generate
        for (genvar g = 0; g < 6; g++) begin : g_lvl
            assign lvl[g] = {priority_high_bits_i[g], priority_low_bits_i[g]}; // R15
        end
    endgenerate
    assign lvl[6] = 2'h0;
    assign pend = poll_reg & interrupt_enable_bits_i;

    logic [3:0] ip_reg;
    always_comb begin
        found = 1'b0;
        sel = 3'h0;
        sel_lvl = 2'h0;
        // Highest level first, lowest index wins a tie
        for (int l = 3; l >= 0; l--) begin
            for (int s = 0; s < 7; s++) begin
                if (!found && pend[s] && lvl[s] == 2'(l)) begin // R18
                    found = 1'b1;
                    sel = 3'(s);
                    sel_lvl = 2'(l);
                end
            end
        end
    end
    logic blocked;
    assign blocked = |(ip_reg >> sel_lvl); // R13

    ////////////////////////////////////////////////////////////////
    // Acknowledge and hardware call
    eipc_pkg::eipc_state_t state_reg;
    logic defer_reg;
    logic ack;
    logic [2:0] src_reg;
    assign ack = cyc_end && state_reg == eipc_pkg::EIPC_IDLE && found && !blocked
        && instr_last_cycle_i && !defer_reg && !instr_defer_next_i; // R11 R12
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            defer_reg <= 1'b0;
        end else if (cyc_end && instr_last_cycle_i) begin
            defer_reg <= instr_defer_next_i; // R12
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= eipc_pkg::EIPC_IDLE;
        end else if (cyc_end) begin
            unique case (state_reg)
                eipc_pkg::EIPC_IDLE: if (ack) state_reg <= eipc_pkg::EIPC_CALL1; // R10
                eipc_pkg::EIPC_CALL1: state_reg <= eipc_pkg::EIPC_CALL2;
                eipc_pkg::EIPC_CALL2: state_reg <= eipc_pkg::EIPC_IDLE;
                default: state_reg <= eipc_pkg::EIPC_IDLE;
            endcase
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            src_reg <= 3'h0;
        end else if (ack) begin
            src_reg <= sel;
        end
    end
    logic call_done;
    assign call_done = cyc_end && state_reg == eipc_pkg::EIPC_CALL2;
    always_comb begin
        ext_clr = 2'h0;
        if (call_done && src_reg == 3'h0 && trig[0]) ext_clr[0] = 1'b1; // R7 R17
        if (call_done && src_reg == 3'h2 && trig[1]) ext_clr[1] = 1'b1; // R7 R17
    end

    ////////////////////////////////////////////////////////////////
    // In-progress levels
    logic [1:0] cur_lvl;
    always_comb begin
        cur_lvl = 2'h0;
        for (int l = 0; l < 4; l++) begin
            if (ip_reg[l]) cur_lvl = 2'(l);
        end
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ip_reg <= eipc_pkg::IP_RESET;
        end else if (ack) begin
            ip_reg[sel_lvl] <= 1'b1;
        end else if (interrupt_return_instr_i) begin
            ip_reg[cur_lvl] <= 1'b0; // R1
        end
        // Subroutine return leaves ip_reg untouched on purpose
    end
    assign in_progress_o = ip_reg;

    ////////////////////////////////////////////////////////////////
    // Stack and program counter strobes, all registered
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            call_active_o <= 1'b0;
            push_o <= 1'b0;
            push_data_o <= 16'h0000;
            pop_o <= 1'b0;
            pc_load_o <= 1'b0;
            pc_load_value_o <= 16'h0000;
            ack_source_o <= 3'h0;
        end else begin
            call_active_o <= (state_reg != eipc_pkg::EIPC_IDLE) || ack; // R10
            push_o <= ack; // R16
            pop_o <= interrupt_return_instr_i || subroutine_return_instr_i; // R1 R2
            pc_load_o <= call_done || interrupt_return_instr_i || subroutine_return_instr_i;
            if (ack) begin
                push_data_o <= pc_i; // R16
                ack_source_o <= sel;
            end
            if (call_done) begin
                pc_load_value_o <= eipc_pkg::VEC_BASE + 16'(src_reg) * eipc_pkg::VEC_STEP; // R16
            end else if (interrupt_return_instr_i || subroutine_return_instr_i) begin
                pc_load_value_o <= stack_pc_i; // R1 R2
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/eipc_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module eipc_monitor #(
    parameter int MCYCLE_CLKS = 12
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [1:0] ext_request_pin_n_i,
    input wire logic ext0_trigger_type_i,
    input wire logic interrupt_return_instr_i,
    input wire logic ext0_request_flag_o,
    input wire logic [3:0] in_progress_o,
    input wire logic call_active_o,
    input wire logic push_o,
    input wire logic pop_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_load_value_o,
    input wire logic [2:0] ack_source_o
);
    localparam int LOAD_DLY = 2 * MCYCLE_CLKS;
    localparam int QUIET = 2 * MCYCLE_CLKS;
    logic [5:0] hi_cnt;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////
    // Two machine cycles of idle pin always include one sample
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hi_cnt <= 6'h00;
        end else if (!ext_request_pin_n_i[0] || ext0_trigger_type_i) begin
            hi_cnt <= 6'h00;
        end else if (hi_cnt != 6'h3F) begin
            hi_cnt <= hi_cnt + 6'h01;
        end
    end
    sequence s_call_end;
        pc_load_o ##1 !call_active_o;
    endsequence
    ////////////////////////////////////////////////////////////////
    a_call_start: assert property ($rose(call_active_o) |-> push_o)
        else $error("call began without push");
    a_call_length: assert property (push_o |-> ##LOAD_DLY s_call_end)
        else $error("call length wrong");
    a_call_spacing: assert property (push_o |=> (!push_o)[*8])
        else $error("calls too close");
    a_vector_map: assert property (pc_load_o && !pop_o |->
        pc_load_value_o == 16'h0003 + {10'h000, ack_source_o, 3'h0})
        else $error("wrong vector");
    a_pop_return: assert property (interrupt_return_instr_i |=> pop_o)
        else $error("no pop after return");
    a_clear_cause: assert property (|($past(in_progress_o) & ~in_progress_o)
        |-> $past(interrupt_return_instr_i))
        else $error("level cleared without return");
    a_flag_low_pin: assert property ($rose(ext0_request_flag_o)
        |-> !ext_request_pin_n_i[0])
        else $error("flag set with pin high");
    a_level_follow: assert property (hi_cnt >= QUIET |-> !ext0_request_flag_o)
        else $error("level flag stuck");
endmodule
`default_nettype wire

// ===== dv/eipc_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module eipc_core_model (
    input wire logic clock_i,
    input wire logic mcycle_i,
    input wire logic slow_i,
    input wire logic push_i,
    input wire logic [15:0] push_data_i,
    output logic last_cycle_o,
    output logic [15:0] pc_o,
    output logic [15:0] stack_pc_o
);
    logic [1:0] cnt;
    initial begin
        cnt = 2'h0;
        last_cycle_o = 1'b1;
        pc_o = 16'h1234;
        stack_pc_o = 16'h0000;
    end
    // Slow mode runs only four-cycle instructions, the worst case
    always @(negedge clock_i) begin
        if (mcycle_i) begin
            cnt <= cnt + 2'h1;
        end
        last_cycle_o <= !slow_i || cnt == 2'h3;
        if (push_i) begin
            stack_pc_o <= push_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== dv/eipc_bench.sv
`timescale 1ns/10ps
`default_nettype none
bind eipc_ctrl eipc_monitor #(.MCYCLE_CLKS(MCYCLE_CLKS)) u_eipc_monitor (.clock_i, .rst_n_i,
    .ext_request_pin_n_i, .ext0_trigger_type_i, .interrupt_return_instr_i,
    .ext0_request_flag_o, .in_progress_o, .call_active_o, .push_o, .pop_o, .pc_load_o,
    .pc_load_value_o, .ack_source_o);
module external_interrupt_priority_ctrl_bench;
    logic clock_i, rst_n_i, ext0_trigger_type_i, ext1_trigger_type_i, instr_last_cycle_i;
    logic interrupt_return_instr_i, subroutine_return_instr_i, slow, mcycle_o, pop_o;
    logic ext0_request_flag_o, ext1_request_flag_o, call_active_o, push_o, pc_load_o;
    logic [1:0] ext_request_pin_n_i;
    logic [6:0] interrupt_enable_bits_i;
    logic [5:0] priority_high_bits_i;
    logic [5:0] priority_low_bits_i;
    logic [15:0] pc_i, stack_pc_i, push_data_o, pc_load_value_o;
    logic [3:0] in_progress_o;
    logic [2:0] ack_source_o;
    int n_fail, comparisons;
    eipc_ctrl u_eipc_ctrl (.clock_i, .rst_n_i, .ext_request_pin_n_i, .ext0_trigger_type_i,
        .ext1_trigger_type_i, .interrupt_enable_bits_i, .priority_low_bits_i,
        .priority_high_bits_i, .int_source_req_i(5'h00), .instr_last_cycle_i,
        .instr_defer_next_i(1'b0), .interrupt_return_instr_i, .subroutine_return_instr_i,
        .pc_i, .stack_pc_i, .mcycle_o, .ext0_request_flag_o, .ext1_request_flag_o,
        .in_progress_o, .call_active_o, .push_o, .push_data_o, .pop_o, .pc_load_o,
        .pc_load_value_o, .ack_source_o);
    eipc_core_model u_eipc_core_model (.clock_i, .mcycle_i(mcycle_o), .slow_i(slow),
        .push_i(push_o), .push_data_i(push_data_o), .last_cycle_o(instr_last_cycle_i),
        .pc_o(pc_i), .stack_pc_o(stack_pc_i));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wait_push(output int n);
        n = 0;
        while (push_o !== 1'b1 && n < 200) begin
            @(negedge clock_i);
            n++;
        end
    endtask
    task automatic pulse(input logic interrupt_return_instr);
        interrupt_return_instr_i = interrupt_return_instr;
        subroutine_return_instr_i = !interrupt_return_instr;
        @(negedge clock_i);
        interrupt_return_instr_i = 1'b0;
        subroutine_return_instr_i = 1'b0;
        chk("pop", 16'h0001, {15'h0, pop_o});
    endtask
    task automatic close_out();
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_level();
        int n;
        ext_request_pin_n_i = 2'b10;
        wait_push(n);
        chk("src", 16'h0000, {13'h0, ack_source_o});
        chk("push", 16'h1234, push_data_o);
        repeat (24) @(negedge clock_i);
        chk("vec", 16'h0003, pc_load_value_o);
        chk("flag0", 16'h0001, {15'h0, ext0_request_flag_o});
        ext_request_pin_n_i = 2'b11;
        pulse(1'b0);
        repeat (30) @(negedge clock_i);
        chk("prog", 16'h0001, {12'h0, in_progress_o});
        chk("flag0", 16'h0000, {15'h0, ext0_request_flag_o});
        pulse(1'b1);
        chk("prog", 16'h0000, {12'h0, in_progress_o});
    endtask
    task automatic t_edge();
        int n;
        slow = 1'b1;
        ext1_trigger_type_i = 1'b1;
        priority_high_bits_i = 6'h04;
        priority_low_bits_i = 6'h04;
        interrupt_enable_bits_i = 7'h05;
        repeat (24) @(negedge clock_i);
        ext_request_pin_n_i = 2'b01;
        wait_push(n);
        chk("src", 16'h0002, {13'h0, ack_source_o});
        chk("resp", 16'h0001, {15'h0, (n + 24 > 36) && (n + 24 < 108)});
        repeat (24) @(negedge clock_i);
        chk("vec", 16'h0013, pc_load_value_o);
        chk("flag1", 16'h0000, {15'h0, ext1_request_flag_o});
        chk("prog", 16'h0008, {12'h0, in_progress_o});
        ext_request_pin_n_i = 2'b10;
        wait_push(n);
        chk("block", 16'h00C8, n[15:0]);
        pulse(1'b1);
        wait_push(n);
        chk("src", 16'h0000, {13'h0, ack_source_o});
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end
    initial begin
        #40000;
        n_fail++;
        close_out();
    end
    initial begin
        {rst_n_i, ext0_trigger_type_i, ext1_trigger_type_i, slow} = 4'h0;
        {interrupt_return_instr_i, subroutine_return_instr_i} = 2'h0;
        ext_request_pin_n_i = 2'b11;
        interrupt_enable_bits_i = 7'h01;
        priority_high_bits_i = 6'h00;
        priority_low_bits_i = 6'h00;
        n_fail = 0;
        comparisons = 0;
        repeat (6) @(negedge clock_i);
        rst_n_i = 1'b1;
        t_level();
        t_edge();
        close_out();
    end
endmodule
`default_nettype wire
